// ---- hw/sub_exec_pkg.sv ----
// Package: encodings, phase codes, flag layout and carriers for the subtract execution unit
package sub_exec_pkg;

  // ==========================================================================
  // Widths and field positions
  // ==========================================================================
  localparam int DATA_W      = 8;               // Data path width
  localparam int INSN_W      = 16;              // Instruction word width
  localparam int NIB_W       = 4;               // Low nibble width for digit carry
  localparam int LIT_LSB     = 0;               // Literal / file address field low bit
  localparam int OP8_LSB     = 8;               // Upper-byte opcode low bit
  localparam int OP6_LSB     = 10;              // Six-bit opcode low bit
  localparam int DEST_BIT    = 9;               // Destination select bit
  localparam int ACCESS_BIT  = 8;               // Access bank select bit
  localparam int SIGN_BIT    = 7;               // Sign bit of an 8-bit value

  // ==========================================================================
  // Opcodes
  // ==========================================================================
  localparam logic [7:0] OPC_SUB_LIT    = 8'h08;   // 0000 1000 kkkk kkkk
  localparam logic [5:0] OPC_SUB_BORROW = 6'h15;   // 0101 01da ffff ffff

  // ==========================================================================
  // Selector codes
  // ==========================================================================
  localparam logic DEST_ACC     = 1'h0;         // Result goes to the accumulator
  localparam logic ACCESS_FORCE = 1'h0;         // Force the access bank
  localparam logic [3:0] ACCESS_BANK = 4'h0;    // Bank used when the access bank is forced

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] ACC_RST  = 8'h00;      // Accumulator after reset

  // ==========================================================================
  // Four-phase instruction cycle, one-hot
  // ==========================================================================
  typedef enum logic [3:0] {
    PH_DECODE  = 4'h1,
    PH_READ    = 4'h2,
    PH_PROCESS = 4'h4,
    PH_WRITE   = 4'h8
  } phase_type;

  // Decoded operation
  typedef enum logic [2:0] {
    OP_NONE   = 3'h1,
    OP_LIT    = 3'h2,
    OP_BORROW = 3'h4
  } op_type;

  // Status flags carried together
  typedef struct packed {
    logic negative;
    logic overflow_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } flags_type;

  // File register access request
  typedef struct packed {
    logic       en;
    logic [3:0] bank;
    logic [7:0] addr;
  } file_addr_type;

endpackage

// ---- hw/sub_alu.sv ----
// Combinational 8-bit subtractor producing result and status flags
`timescale 1ns/1ps
`default_nettype none

module sub_alu
  import sub_exec_pkg::*;
#(
  parameter int W = DATA_W
) (
  input  wire logic [W-1:0] minuend,
  input  wire logic [W-1:0] subtrahend,
  input  wire logic         carryIn,
  output logic      [W-1:0] diff,
  output flags_type         flags
);

  // ==========================================================================
  // Subtraction as a + ~b + carryIn; carry out is the inverted borrow
  // ==========================================================================
  logic [W:0]       full;          // Sum with carry out
  logic [NIB_W:0]   low;           // Low nibble sum with nibble carry
  logic [W-1:0]     nb;            // Inverted subtrahend

  always_comb begin
    nb   = ~subtrahend;
    full = {1'b0, minuend} + {1'b0, nb} + {{W{1'b0}}, carryIn};
    low  = {1'b0, minuend[NIB_W-1:0]} + {1'b0, nb[NIB_W-1:0]}
         + {{NIB_W{1'b0}}, carryIn};
    diff = full[W-1:0];
    flags.carry            = full[W];
    flags.digit_carry_flag = low[NIB_W];
    flags.zero             = (full[W-1:0] == '0);
    flags.negative         = full[W-1];
    // Signs differ and result sign differs from minuend: out of -128..127
    flags.overflow_flag    = (minuend[W-1] ^ subtrahend[W-1])
                           & (minuend[W-1] ^ full[W-1]);
  end

endmodule

`default_nettype wire

// ---- hw/subtract_literal_and_borrow_exec.sv ----
// Execution unit for the literal subtract and the subtract-with-borrow instructions
`timescale 1ns/1ps
`default_nettype none

module subtract_literal_and_borrow_exec
  import sub_exec_pkg::*;
#(
  parameter int W = DATA_W
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [INSN_W-1:0]   insnWord,      // Fetched word, sampled at the end of phase one
  input  wire logic [3:0]          bankSelector,  // Current bank_selector value
  input  wire logic [W-1:0]        fileRdData,    // File register read data
  input  wire flags_type           statusIn,      // Status register as held by the core
  output file_addr_type            fileRd,        // File read request (phase two)
  output file_addr_type            fileWr,        // File write request (one clock after phase four)
  output logic      [W-1:0]        fileWrData,    // File write data
  output logic      [W-1:0]        acc,           // Accumulator
  output logic                     statusWe,      // Status write strobe (one clock after phase four)
  output flags_type                statusOut,     // New status flags
  output phase_type                phase,         // Current phase
  output logic                     insnDone       // Pulse at the end of each cycle
);

  // ==========================================================================
  // State
  // ==========================================================================
  phase_type     phase_ff;        // Four-phase sequencer
  op_type        op_ff;           // Operation latched in decode
  logic          dest_ff;         // Destination select
  logic [7:0]    lit_ff;          // Literal or file address
  logic [3:0]    bank_ff;         // Resolved bank
  logic [W-1:0]  opnd_ff;         // Operand read in phase two
  logic [W-1:0]  res_ff;          // Result computed in phase three
  flags_type     flg_ff;          // Flags computed in phase three
  logic [W-1:0]  acc_ff;          // Accumulator
  file_addr_type fileRd_ff;       // Registered read request
  file_addr_type fileWr_ff;       // Registered write request
  logic [W-1:0]  fileWrData_ff;   // Registered write data
  logic          statusWe_ff;     // Registered status strobe
  flags_type     statusOut_ff;    // Registered status value

  // ==========================================================================
  // Decode of the current word
  // ==========================================================================
  op_type     nxt_op;
  logic [3:0] nxt_bank;

  // Opcode compare; anything else is left to the rest of the core
  always_comb begin
    if (insnWord[INSN_W-1:OP8_LSB] == OPC_SUB_LIT) begin
      nxt_op = OP_LIT;
    end else if (insnWord[INSN_W-1:OP6_LSB] == OPC_SUB_BORROW) begin
      nxt_op = OP_BORROW;
    end else begin
      nxt_op = OP_NONE;
    end
    // Access bit 0 forces the access bank, 1 takes the bank_selector
    nxt_bank = (insnWord[ACCESS_BIT] == ACCESS_FORCE) ? ACCESS_BANK
                                                      : bankSelector;
  end

  // ==========================================================================
  // Arithmetic
  // ==========================================================================
  logic [W-1:0] minuend;
  logic [W-1:0] subtrahend;
  logic         cin;
  logic [W-1:0] diff;
  flags_type    aluFlags;

  // Literal op: k - acc with no borrow in; borrow op: acc - f - ~C
  always_comb begin
    if (op_ff == OP_LIT) begin
      minuend    = lit_ff;
      subtrahend = acc_ff;
      cin        = 1'b1;
    end else begin
      minuend    = acc_ff;
      subtrahend = opnd_ff;
      cin        = statusIn.carry;
    end
  end

  sub_alu #(
    .W (W)
  ) u_alu (
    .minuend    (minuend),
    .subtrahend (subtrahend),
    .carryIn    (cin),
    .diff       (diff),
    .flags      (aluFlags)
  );

  // ==========================================================================
  // Phase sequencer: one instruction cycle is four clocks
  // ==========================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_ff <= PH_DECODE;
    end else begin
      unique case (phase_ff)
        PH_DECODE:  phase_ff <= PH_READ;
        PH_READ:    phase_ff <= PH_PROCESS;
        PH_PROCESS: phase_ff <= PH_WRITE;
        PH_WRITE:   phase_ff <= PH_DECODE;
      endcase
    end
  end

  // ==========================================================================
  // Decode latch (phase one)
  // ==========================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      op_ff   <= OP_NONE;
      dest_ff <= DEST_ACC;
      lit_ff  <= '0;
      bank_ff <= '0;
    end else if (phase_ff == PH_DECODE) begin
      op_ff   <= nxt_op;
      dest_ff <= insnWord[DEST_BIT];
      lit_ff  <= insnWord[OP8_LSB-1:LIT_LSB];
      bank_ff <= nxt_bank;
    end
  end

  // ==========================================================================
  // Operand read (phase two); file data sampled at the end of the phase
  // ==========================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      opnd_ff   <= '0;
      fileRd_ff <= '0;
    end else begin
      // Request is raised for the read phase only, so the file sees one access
      fileRd_ff.en   <= (phase_ff == PH_DECODE) && (nxt_op == OP_BORROW);
      fileRd_ff.bank <= (phase_ff == PH_DECODE) ? nxt_bank : fileRd_ff.bank;
      fileRd_ff.addr <= (phase_ff == PH_DECODE) ? insnWord[OP8_LSB-1:LIT_LSB]
                                                : fileRd_ff.addr;
      if (phase_ff == PH_READ) begin
        opnd_ff <= (op_ff == OP_LIT) ? lit_ff : fileRdData;
      end
    end
  end

  // ==========================================================================
  // Compute (phase three)
  // ==========================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      res_ff <= '0;
      flg_ff <= '0;
    end else if (phase_ff == PH_PROCESS) begin
      res_ff <= diff;
      flg_ff <= aluFlags;
    end
  end

  // ==========================================================================
  // Write back (phase four)
  // ==========================================================================
  logic doWrite;
  logic toAcc;

  // Literal subtract always lands in the accumulator
  always_comb begin
    doWrite = (phase_ff == PH_WRITE) && (op_ff != OP_NONE);
    toAcc   = (op_ff == OP_LIT) || (dest_ff == DEST_ACC);
  end

  // Accumulator update
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_ff <= ACC_RST;
    end else if (doWrite && toAcc) begin
      acc_ff <= res_ff;
    end
  end

  // File write request, registered so it shows one clock after phase four
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fileWr_ff     <= '0;
      fileWrData_ff <= '0;
    end else begin
      fileWr_ff.en   <= doWrite && !toAcc;
      fileWr_ff.bank <= bank_ff;
      fileWr_ff.addr <= lit_ff;
      fileWrData_ff  <= res_ff;
    end
  end

  // Status update for both operations
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      statusWe_ff  <= 1'b0;
      statusOut_ff <= '0;
    end else begin
      statusWe_ff  <= doWrite;
      statusOut_ff <= doWrite ? flg_ff : statusOut_ff;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign acc        = acc_ff;
  assign fileRd     = fileRd_ff;
  assign fileWr     = fileWr_ff;
  assign fileWrData = fileWrData_ff;
  assign statusWe   = statusWe_ff;
  assign statusOut  = statusOut_ff;
  assign phase      = phase_ff;
  assign insnDone   = (phase_ff == PH_WRITE);

endmodule

`default_nettype wire

// ---- verification/sub_exec_monitor.sv ----
// Checker for the ports of the subtract execution unit
`timescale 1ns/1ps
`default_nettype none

module sub_exec_monitor
  import sub_exec_pkg::*;
#(
  parameter int W = DATA_W
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [INSN_W-1:0] insnWord,
  input wire logic [3:0]        bankSelector,
  input wire logic [W-1:0]      fileRdData,
  input wire flags_type         statusIn,
  input wire file_addr_type     fileRd,
  input wire file_addr_type     fileWr,
  input wire logic [W-1:0]      fileWrData,
  input wire logic [W-1:0]      acc,
  input wire logic              statusWe,
  input wire flags_type         statusOut,
  input wire phase_type         phase,
  input wire logic              insnDone
);
  // ==========================================================================
  // Helper state
  // ==========================================================================
  logic [INSN_W-1:0] insnHeld_ff;   // Word taken at the end of decode
  logic [3:0]        bankHeld_ff;   // Bank selector taken with it
  logic [W-1:0]      fileHeld_ff;   // File data taken at the end of read
  logic              isLit;         // Held word is the literal subtract
  logic              isBor;         // Held word is the borrow subtract
  logic              litNoBorrow;   // Literal not below accumulator
  logic [W-1:0]      litDiff;       // Expected literal result
  logic [W-1:0]      borDiff;       // Expected borrow result

  // Capture at decode end, same edge the unit uses
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      insnHeld_ff <= '0;
      bankHeld_ff <= '0;
    end else if (phase == PH_DECODE) begin
      insnHeld_ff <= insnWord;
      bankHeld_ff <= bankSelector;
    end
  end

  // Operand is only valid at the end of read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fileHeld_ff <= '0;
    end else if (phase == PH_READ) begin
      fileHeld_ff <= fileRdData;
    end
  end

  // Reference results; bench holds statusIn for the whole cycle
  always_comb begin
    isLit       = insnHeld_ff[15:8] == OPC_SUB_LIT;
    isBor       = insnHeld_ff[15:10] == OPC_SUB_BORROW;
    litDiff     = W'(insnHeld_ff[7:0]) - acc;
    litNoBorrow = W'(insnHeld_ff[7:0]) >= acc;
    borDiff     = acc - fileHeld_ff - W'(!statusIn.carry);
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  phase_order_a: assert property ((phase == PH_DECODE) |=> (phase == PH_READ) ##1
    (phase == PH_PROCESS) ##1 (phase == PH_WRITE) ##1 (phase == PH_DECODE))
    else $error("phase sequence broken");
  done_phase_a: assert property (insnDone == (phase == PH_WRITE))
    else $error("done not aligned to write phase");
  lit_result_a: assert property ((phase == PH_WRITE && isLit) |=> acc == $past(litDiff))
    else $error("literal result wrong");
  lit_flags_a: assert property ((phase == PH_WRITE && isLit) |=>
    statusOut.carry == $past(litNoBorrow) && statusOut.zero == (acc == '0)
    && statusOut.negative == acc[W-1]) else $error("literal flags wrong");
  bor_acc_a: assert property ((phase == PH_WRITE && isBor && !insnHeld_ff[DEST_BIT])
    |=> acc == $past(borDiff) && !fileWr.en) else $error("borrow to accumulator wrong");
  bor_file_a: assert property ((phase == PH_WRITE && isBor && insnHeld_ff[DEST_BIT])
    |=> fileWr.en && fileWrData == $past(borDiff) && fileWr.addr == insnHeld_ff[7:0]
    && fileWr.bank == (insnHeld_ff[ACCESS_BIT] ? bankHeld_ff : ACCESS_BANK)
    && $stable(acc)) else $error("borrow to file wrong");
  read_req_a: assert property ((phase == PH_READ && isBor) |-> fileRd.en)
    else $error("file read missing");
  read_addr_a: assert property (fileRd.en |-> phase == PH_READ && isBor
    && fileRd.addr == insnHeld_ff[7:0]
    && fileRd.bank == (insnHeld_ff[ACCESS_BIT] ? bankHeld_ff : ACCESS_BANK))
    else $error("file read request wrong");
  status_pulse_a: assert property ((phase == PH_WRITE && (isLit || isBor))
    |=> statusWe ##1 !statusWe) else $error("status strobe wrong");
  noop_quiet_a: assert property ((phase == PH_WRITE && !isLit && !isBor)
    |=> $stable(acc) && !statusWe && !fileWr.en) else $error("unknown word caused a write");

  lit_seen_c: cover property (phase == PH_WRITE && isLit);
  bor_file_c: cover property (fileWr.en);
  bor_acc_c: cover property (phase == PH_WRITE && isBor && !insnHeld_ff[DEST_BIT]);
endmodule

bind subtract_literal_and_borrow_exec sub_exec_monitor #(.W(W)) u_sub_exec_monitor (
  .clk(clk), .reset(reset), .insnWord(insnWord), .bankSelector(bankSelector),
  .fileRdData(fileRdData), .statusIn(statusIn), .fileRd(fileRd), .fileWr(fileWr),
  .fileWrData(fileWrData), .acc(acc), .statusWe(statusWe), .statusOut(statusOut),
  .phase(phase), .insnDone(insnDone));

`default_nettype wire

// ---- verification/tb_subtract_literal_and_borrow_exec.sv ----
// Self-checking testbench for the subtract execution unit
`timescale 1ns/1ps
`default_nettype none

module tb_subtract_literal_and_borrow_exec
  import sub_exec_pkg::*;
;
  localparam logic [15:0] NOP = 16'hFFFF;  // Matches no opcode
  localparam int LIMIT = 2000;             // Run needs under two hundred cycles

  logic          clk = 1'b0;
  logic          reset = 1'b1;
  logic [15:0]   insnWord;
  logic [3:0]    bankSelector;
  logic [7:0]    fileRdData;
  flags_type     statusIn;
  file_addr_type fileRd;
  file_addr_type fileWr;
  logic [7:0]    fileWrData;
  logic [7:0]    acc;
  logic          statusWe;
  flags_type     statusOut;
  phase_type     phase;
  logic          insnDone;
  int            mismatches = 0;
  int            tests_run = 0;
  int            cycles = 0;
  logic [7:0]    accModel = ACC_RST;   // Accumulator as the bench expects it

  always #25 clk = ~clk;

  subtract_literal_and_borrow_exec u_subtract_literal_and_borrow_exec (
    .clk(clk), .reset(reset), .insnWord(insnWord), .bankSelector(bankSelector),
    .fileRdData(fileRdData), .statusIn(statusIn), .fileRd(fileRd), .fileWr(fileWr),
    .fileWrData(fileWrData), .acc(acc), .statusWe(statusWe), .statusOut(statusOut),
    .phase(phase), .insnDone(insnDone));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  // Reference: m - s - !c, flags packed negative first and carry last, above the result
  function automatic logic [12:0] ref_sub(input logic [7:0] m, input logic [7:0] s,
                                          input logic c);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, m} + {1'b0, ~s} + 9'(c);
    low = {1'b0, m[3:0]} + {1'b0, ~s[3:0]} + 5'(c);
    ref_sub = {full[7], (m[7] != s[7]) && (full[7] != m[7]), full[7:0] == 8'h00,
               low[4], full[8], full[7:0]};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One instruction into the next free decode slot, then judge all ports
  task automatic exec(input logic [15:0] w, input logic [7:0] f, input logic c,
                      output logic [12:0] e);
    logic lit;
    logic bor;
    lit = w[15:8] == OPC_SUB_LIT;
    bor = w[15:10] == OPC_SUB_BORROW;
    e = lit ? ref_sub(w[7:0], accModel, 1'b1) : ref_sub(accModel, f, c);
    while (phase !== PH_WRITE) @(negedge clk);
    @(posedge clk);
    insnWord <= w;
    bankSelector <= w[3:0] ^ 4'h6;
    fileRdData <= f;
    statusIn <= {4'hF, c};
    @(posedge clk);
    insnWord <= NOP;
    @(negedge clk);
    check("rd_en", 16'(fileRd.en), 16'(bor));
    if (bor) check("rd_addr", 16'({fileRd.bank, fileRd.addr}),
                   {4'h0, w[8] ? bankSelector : ACCESS_BANK, w[7:0]});
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("done", 16'({insnDone, phase}), 16'({1'b1, PH_WRITE}));
    @(negedge clk);
    check("we", 16'({statusWe, fileWr.en}), 16'({lit | bor, bor & w[9]}));
    if (lit | (bor & !w[9])) accModel = e[7:0];
    check("acc", 16'(acc), 16'(accModel));
    if (lit | bor) check("flags", 16'(statusOut), 16'(e[12:8]));
    if (bor & w[9]) check("wr", {fileWr.addr, fileWrData}, {w[7:0], e[7:0]});
    if (bor & w[9]) check("wr_bank", 16'(fileWr.bank),
                          16'(w[8] ? bankSelector : ACCESS_BANK));
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Worked examples, boundary literals and both overflow directions
  task automatic t_literal();
    logic [7:0]  ks [10] = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h03, 8'h02, 8'h00, 8'h80,
                            8'hFF, 8'h7F};
    logic [12:0] e;
    foreach (ks[i]) begin
      exec({OPC_SUB_LIT, ks[i]}, 8'h5A, 1'b0, e);
      if (i == 5) check("wrap", 16'({acc, statusOut.negative, statusOut.carry}), 16'h03FE);
    end
    $display("literal test done");
  endtask

  // Borrow subtract: both destinations, both bank modes, carry in 0 and 1
  task automatic t_borrow();
    logic [7:0]  ws [4] = '{8'h02, 8'h05, 8'h02, 8'h80};
    logic [7:0]  rs [4] = '{8'h03, 8'h02, 8'h01, 8'h01};
    logic [12:0] e;
    foreach (ws[i]) begin
      exec({OPC_SUB_LIT, 8'(ws[i] + accModel)}, 8'h00, 1'b0, e);
      exec({OPC_SUB_BORROW, !i[0], i[1], 8'hC3 ^ 8'(i)}, rs[i], i != 2, e);
      if (i == 2) check("zero", 16'({statusOut.zero, statusOut.carry}), 16'h0003);
    end
    $display("borrow test done");
  endtask

  // Near-miss opcodes must leave every target alone
  task automatic t_noop();
    logic [15:0] ws [4] = '{16'h0900, 16'h5812, 16'h5C12, 16'h0000};
    logic [12:0] e;
    foreach (ws[i]) exec(ws[i], 8'h33, 1'b1, e);
    $display("unknown word test done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("[FAIL] timeout after %0d cycles", LIMIT);
      print_verdict();
    end
  end

  initial begin
    insnWord = NOP;
    bankSelector = 4'h0;
    fileRdData = 8'h00;
    statusIn = '0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_literal();
    t_borrow();
    t_noop();
    print_verdict();
  end
endmodule

`default_nettype wire
